// [logic/acb_cfg.svh]
// Offsets, field widths, bit positions and reset values of the calibration value bank.
// Assumes byte addressing on an APB bus with 32-bit data, one aligned word per register.
`ifndef ACB_CFG_SVH
`define ACB_CFG_SVH

`define ACB_NUM_REGS    11
`define ACB_MAX_W       10

`define ACB_OFS_PLUS3   8'h40
`define ACB_OFS_PLUS2   8'h44
`define ACB_OFS_PLUS1   8'h48
`define ACB_OFS_PLUS0   8'h4C
`define ACB_OFS_MINUSD  8'h54
`define ACB_OFS_MINUSS  8'h58
`define ACB_OFS_MINUS4  8'h5C
`define ACB_OFS_MINUS3  8'h60
`define ACB_OFS_MINUS2  8'h64
`define ACB_OFS_MINUS1  8'h68
`define ACB_OFS_MINUS0  8'h6C
`define ACB_OFS_STATUS  8'h70
`define ACB_OFS_CTRL    8'h74

`define ACB_W_PLUS3     9
`define ACB_W_PLUS2     8
`define ACB_W_PLUS1     7
`define ACB_W_PLUS0     6
`define ACB_W_MINUSD    6
`define ACB_W_MINUSS    6
`define ACB_W_MINUS4    10
`define ACB_W_MINUS3    9
`define ACB_W_MINUS2    8
`define ACB_W_MINUS1    7
`define ACB_W_MINUS0    6

`define ACB_ST_LOADED   0
`define ACB_ST_OVERWR   1
`define ACB_ST_BUSY     2
`define ACB_CTRL_LOCK   0

`define ACB_VAL_RST     10'h000
`define ACB_RD_ZERO     32'h0000_0000

`endif

// [logic/acb_pkg.sv]
// Types shared by the calibration value bank modules.
// Assumes acb_cfg.svh is on the include path.
`include "acb_cfg.svh"
package acb_pkg;

  typedef struct packed {
    logic [`ACB_W_PLUS3-1:0]  plus_value3;
    logic [`ACB_W_PLUS2-1:0]  plus_value2;
    logic [`ACB_W_PLUS1-1:0]  plus_value1;
    logic [`ACB_W_PLUS0-1:0]  plus_value0;
    logic [`ACB_W_MINUSD-1:0] minus_value_d;
    logic [`ACB_W_MINUSS-1:0] minus_value_s;
    logic [`ACB_W_MINUS4-1:0] minus_value4;
    logic [`ACB_W_MINUS3-1:0] minus_value3;
    logic [`ACB_W_MINUS2-1:0] minus_value2;
    logic [`ACB_W_MINUS1-1:0] minus_value1;
    logic [`ACB_W_MINUS0-1:0] minus_value0;
  } acb_cal_set_t;

  typedef struct packed {
    logic        wr_en;
    logic        rd_en;
    logic [7:0]  addr;
    logic [31:0] wdata;
  } acb_reg_acc_t;

endpackage : acb_pkg

// [logic/acb_cal_reg.sv]
// One calibration value register of parameterised width.
// Assumes load and write strobes are single-cycle and on the same clock.
`timescale 1ns/10ps
`include "acb_cfg.svh"
module acb_cal_reg #(
  parameter int WIDTH = 6
) (
  input  wire logic             clk,
  input  wire logic             rst_n,
  input  wire logic             load,
  input  wire logic [WIDTH-1:0] load_val,
  input  wire logic             wr,
  input  wire logic [WIDTH-1:0] wr_val,
  output logic      [WIDTH-1:0] value_q
);

  if (WIDTH < 1 || WIDTH > `ACB_MAX_W) begin : g_bad_width
    $error("acb_cal_reg: unsupported WIDTH");
  end

  // Engine load beats software write
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      value_q <= WIDTH'(`ACB_VAL_RST);
    end else if (load) begin
      value_q <= load_val;
    end else if (wr) begin
      value_q <= wr_val;
    end
  end

endmodule : acb_cal_reg

// [logic/acb_apb_slave.sv]
// APB slave front end: zero wait states, read data captured in the setup cycle.
// Assumes the register decode answers hit and read data combinationally from addr.
`timescale 1ns/10ps
`include "acb_cfg.svh"
module acb_apb_slave (
  input  wire logic                 clk,
  input  wire logic                 rst_n,
  input  wire logic                 psel,
  input  wire logic                 penable,
  input  wire logic                 pwrite,
  input  wire logic [7:0]           paddr,
  input  wire logic [31:0]          pwdata,
  input  wire logic                 hit,
  input  wire logic [31:0]          rdata,
  output logic                      pready,
  output logic                      pslverr,
  output logic      [31:0]          prdata_q,
  output acb_pkg::acb_reg_acc_t     acc
);

  logic setup;
  logic access;

  assign setup     = psel & ~penable;
  assign access    = psel & penable;
  assign pready    = 1'b1;
  assign pslverr   = access & ~hit;
  assign acc.wr_en = access & pwrite & hit;
  assign acc.rd_en = setup & ~pwrite;
  assign acc.addr  = paddr;
  assign acc.wdata = pwdata;

  // Read data held through the access phase
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      prdata_q <= `ACB_RD_ZERO;
    end else if (acc.rd_en) begin
      prdata_q <= hit ? rdata : `ACB_RD_ZERO;
    end
  end

endmodule : acb_apb_slave

// [logic/acb_top.sv]
// Calibration value bank: four plus-side and seven minus-side values behind APB.
// Assumes CAL_ACTIVE and CAL_RESULT come from the calibration engine on CORE_CLK.
//
// Local design decision: the APB register port.
`timescale 1ns/10ps
`include "acb_cfg.svh"
module acb_top (
  input  wire logic                 CORE_CLK,
  input  wire logic                 RST_N,
  input  wire logic                 PSEL,
  input  wire logic                 PENABLE,
  input  wire logic                 PWRITE,
  input  wire logic [7:0]           PADDR,
  input  wire logic [31:0]          PWDATA,
  output logic      [31:0]          PRDATA,
  output logic                      PREADY,
  output logic                      PSLVERR,
  input  wire logic                 CAL_ACTIVE,
  input  wire acb_pkg::acb_cal_set_t CAL_RESULT,
  output acb_pkg::acb_cal_set_t     CAL_VALUES
);

  localparam int NUM = `ACB_NUM_REGS;
  localparam int MW  = `ACB_MAX_W;

  // Register index to width
  function automatic int reg_width(input int idx);
    case (idx)
      0:       reg_width = `ACB_W_PLUS3;
      1:       reg_width = `ACB_W_PLUS2;
      2:       reg_width = `ACB_W_PLUS1;
      3:       reg_width = `ACB_W_PLUS0;
      4:       reg_width = `ACB_W_MINUSD;
      5:       reg_width = `ACB_W_MINUSS;
      6:       reg_width = `ACB_W_MINUS4;
      7:       reg_width = `ACB_W_MINUS3;
      8:       reg_width = `ACB_W_MINUS2;
      9:       reg_width = `ACB_W_MINUS1;
      default: reg_width = `ACB_W_MINUS0;
    endcase
  endfunction : reg_width

  // Register index to byte offset
  function automatic logic [7:0] reg_offset(input int idx);
    case (idx)
      0:       reg_offset = `ACB_OFS_PLUS3;
      1:       reg_offset = `ACB_OFS_PLUS2;
      2:       reg_offset = `ACB_OFS_PLUS1;
      3:       reg_offset = `ACB_OFS_PLUS0;
      4:       reg_offset = `ACB_OFS_MINUSD;
      5:       reg_offset = `ACB_OFS_MINUSS;
      6:       reg_offset = `ACB_OFS_MINUS4;
      7:       reg_offset = `ACB_OFS_MINUS3;
      8:       reg_offset = `ACB_OFS_MINUS2;
      9:       reg_offset = `ACB_OFS_MINUS1;
      default: reg_offset = `ACB_OFS_MINUS0;
    endcase
  endfunction : reg_offset

  acb_pkg::acb_reg_acc_t acc;
  logic [MW-1:0]         load_val [NUM];
  logic [MW-1:0]         cur_val  [NUM];
  logic [NUM-1:0]        sel;
  logic [NUM-1:0]        wr_hit;
  logic                  sel_status;
  logic                  sel_ctrl;
  logic                  hit;
  logic [31:0]           rd_mux;
  logic                  cal_active_q;
  logic                  cal_done;
  logic                  loaded_q;
  logic                  overwr_q;
  logic                  lock_q;
  logic                  sw_cal_wr;

  // Bus front end
  acb_apb_slave u_apb (
    .clk      (CORE_CLK),
    .rst_n    (RST_N),
    .psel     (PSEL),
    .penable  (PENABLE),
    .pwrite   (PWRITE),
    .paddr    (PADDR),
    .pwdata   (PWDATA),
    .hit      (hit),
    .rdata    (rd_mux),
    .pready   (PREADY),
    .pslverr  (PSLVERR),
    .prdata_q (PRDATA),
    .acc      (acc)
  );

  // End of calibration is the falling edge of the active bit
  always_ff @(posedge CORE_CLK or negedge RST_N) begin
    if (!RST_N) begin
      cal_active_q <= 1'b0;
    end else begin
      cal_active_q <= CAL_ACTIVE;
    end
  end

  assign cal_done = cal_active_q & ~CAL_ACTIVE;

  // Engine results, zero-extended per index
  assign load_val[0]  = MW'(CAL_RESULT.plus_value3);
  assign load_val[1]  = MW'(CAL_RESULT.plus_value2);
  assign load_val[2]  = MW'(CAL_RESULT.plus_value1);
  assign load_val[3]  = MW'(CAL_RESULT.plus_value0);
  assign load_val[4]  = MW'(CAL_RESULT.minus_value_d);
  assign load_val[5]  = MW'(CAL_RESULT.minus_value_s);
  assign load_val[6]  = MW'(CAL_RESULT.minus_value4);
  assign load_val[7]  = MW'(CAL_RESULT.minus_value3);
  assign load_val[8]  = MW'(CAL_RESULT.minus_value2);
  assign load_val[9]  = MW'(CAL_RESULT.minus_value1);
  assign load_val[10] = MW'(CAL_RESULT.minus_value0);

  // Value registers, one per index
  for (genvar i = 0; i < NUM; i++) begin : g_reg
    localparam int         W   = reg_width(i);
    localparam logic [7:0] OFS = reg_offset(i);

    assign sel[i]    = (acc.addr == OFS);
    assign wr_hit[i] = acc.wr_en & sel[i] & ~lock_q;

    acb_cal_reg #(
      .WIDTH (W)
    ) u_val (
      .clk      (CORE_CLK),
      .rst_n    (RST_N),
      .load     (cal_done),
      .load_val (load_val[i][W-1:0]),
      .wr       (wr_hit[i]),
      .wr_val   (acc.wdata[W-1:0]),
      .value_q  (cur_val[i][W-1:0])
    );

    if (W < MW) begin : g_pad
      assign cur_val[i][MW-1:W] = '0;
    end
  end

  // Stored values out to the converter
  assign CAL_VALUES.plus_value3   = cur_val[0][`ACB_W_PLUS3-1:0];
  assign CAL_VALUES.plus_value2   = cur_val[1][`ACB_W_PLUS2-1:0];
  assign CAL_VALUES.plus_value1   = cur_val[2][`ACB_W_PLUS1-1:0];
  assign CAL_VALUES.plus_value0   = cur_val[3][`ACB_W_PLUS0-1:0];
  assign CAL_VALUES.minus_value_d = cur_val[4][`ACB_W_MINUSD-1:0];
  assign CAL_VALUES.minus_value_s = cur_val[5][`ACB_W_MINUSS-1:0];
  assign CAL_VALUES.minus_value4  = cur_val[6][`ACB_W_MINUS4-1:0];
  assign CAL_VALUES.minus_value3  = cur_val[7][`ACB_W_MINUS3-1:0];
  assign CAL_VALUES.minus_value2  = cur_val[8][`ACB_W_MINUS2-1:0];
  assign CAL_VALUES.minus_value1  = cur_val[9][`ACB_W_MINUS1-1:0];
  assign CAL_VALUES.minus_value0  = cur_val[10][`ACB_W_MINUS0-1:0];

  assign sel_status = (acc.addr == `ACB_OFS_STATUS);
  assign sel_ctrl   = (acc.addr == `ACB_OFS_CTRL);
  assign sw_cal_wr  = |wr_hit;

  // Read mux and address decode
  always_comb begin
    rd_mux = `ACB_RD_ZERO;
    hit    = sel_status | sel_ctrl;
    for (int k = 0; k < NUM; k++) begin
      if (sel[k]) begin
        rd_mux = 32'(cur_val[k]);
        hit    = 1'b1;
      end
    end
    if (sel_status) begin
      rd_mux[`ACB_ST_LOADED] = loaded_q;
      rd_mux[`ACB_ST_OVERWR] = overwr_q;
      rd_mux[`ACB_ST_BUSY]   = cal_active_q;
    end
    if (sel_ctrl) begin
      rd_mux[`ACB_CTRL_LOCK] = lock_q;
    end
  end

  // Loaded flag: set by finished calibration, write 1 clears, set wins
  always_ff @(posedge CORE_CLK or negedge RST_N) begin
    if (!RST_N) begin
      loaded_q <= 1'b0;
    end else if (cal_done) begin
      loaded_q <= 1'b1;
    end else if (acc.wr_en && sel_status && acc.wdata[`ACB_ST_LOADED]) begin
      loaded_q <= 1'b0;
    end
  end

  // Overwrite flag: software changed a value after calibration
  always_ff @(posedge CORE_CLK or negedge RST_N) begin
    if (!RST_N) begin
      overwr_q <= 1'b0;
    end else if (sw_cal_wr && loaded_q && !cal_done) begin
      overwr_q <= 1'b1;
    end else if (acc.wr_en && sel_status && acc.wdata[`ACB_ST_OVERWR]) begin
      overwr_q <= 1'b0;
    end
  end

  // Write lock for the value registers
  always_ff @(posedge CORE_CLK or negedge RST_N) begin
    if (!RST_N) begin
      lock_q <= 1'b0;
    end else if (acc.wr_en && sel_ctrl) begin
      lock_q <= acc.wdata[`ACB_CTRL_LOCK];
    end
  end

  // Checks
  default clocking cb_chk @(posedge CORE_CLK);
  endclocking
  default disable iff (!RST_N);

  property p_rsv_zero;
    (PSEL && PENABLE && !PWRITE && (|sel)) |-> (PRDATA[31:MW] == '0);
  endproperty
  a_rsv_zero: assert property (p_rsv_zero)
    else $error("reserved bits of a value register read nonzero");

  property p_rd_width;
    (PSEL && !PENABLE && !PWRITE && sel[6]) |=> (PRDATA == 32'($past(cur_val[6])));
  endproperty
  a_rd_width: assert property (p_rd_width)
    else $error("minus word 4 read data differs from stored value");

  property p_minus_load;
    cal_done |=> ({CAL_VALUES.minus_value_d, CAL_VALUES.minus_value_s,
                   CAL_VALUES.minus_value4, CAL_VALUES.minus_value3,
                   CAL_VALUES.minus_value2, CAL_VALUES.minus_value1,
                   CAL_VALUES.minus_value0} ==
                  $past({CAL_RESULT.minus_value_d, CAL_RESULT.minus_value_s,
                         CAL_RESULT.minus_value4, CAL_RESULT.minus_value3,
                         CAL_RESULT.minus_value2, CAL_RESULT.minus_value1,
                         CAL_RESULT.minus_value0}));
  endproperty
  a_minus_load: assert property (p_minus_load)
    else $error("minus values not loaded at end of calibration");

  property p_plus_load;
    $fell(CAL_ACTIVE) |=> ({CAL_VALUES.plus_value3, CAL_VALUES.plus_value2,
                            CAL_VALUES.plus_value1, CAL_VALUES.plus_value0} ==
                           $past({CAL_RESULT.plus_value3, CAL_RESULT.plus_value2,
                                  CAL_RESULT.plus_value1, CAL_RESULT.plus_value0}));
  endproperty
  a_plus_load: assert property (p_plus_load)
    else $error("plus values not loaded at end of calibration");

  property p_minus_own;
    (wr_hit[5] && !cal_done) |=>
      (CAL_VALUES.minus_value_s == $past(PWDATA[`ACB_W_MINUSS-1:0])) &&
      $stable(CAL_VALUES.minus_value_d) && $stable(CAL_VALUES.minus_value0);
  endproperty
  a_minus_own: assert property (p_minus_own)
    else $error("minus word S write leaked into another register");

  property p_w_minus4;
    (wr_hit[6] && !cal_done) |=> (CAL_VALUES.minus_value4 == $past(PWDATA[9:0]));
  endproperty
  a_w_minus4: assert property (p_w_minus4)
    else $error("minus word 4 did not take bits 9 to 0");

  property p_w_plus3;
    (wr_hit[0] && !cal_done) |=> (CAL_VALUES.plus_value3 == $past(PWDATA[8:0]));
  endproperty
  a_w_plus3: assert property (p_w_plus3)
    else $error("plus word 3 did not take bits 8 to 0");

  property p_load_wins;
    (cal_done && acc.wr_en) |=> (CAL_VALUES == $past(CAL_RESULT));
  endproperty
  a_load_wins: assert property (p_load_wins)
    else $error("software write beat a finished calibration");

  property p_lock_hold;
    (lock_q && !cal_done) |=> $stable(CAL_VALUES);
  endproperty
  a_lock_hold: assert property (p_lock_hold)
    else $error("locked value registers changed without calibration");

  property p_loaded_flag;
    cal_done |=> loaded_q ##1 (loaded_q || $past(acc.wr_en && sel_status));
  endproperty
  a_loaded_flag: assert property (p_loaded_flag)
    else $error("loaded flag not set after calibration");

  property p_unmapped;
    (PSEL && PENABLE && !hit) |-> (PSLVERR && (PWRITE || PRDATA == '0));
  endproperty
  a_unmapped: assert property (p_unmapped)
    else $error("unmapped access not answered with error and zero");

  property p_mapped_ok;
    (PSEL && PENABLE && hit) |-> !PSLVERR;
  endproperty
  a_mapped_ok: assert property (p_mapped_ok)
    else $error("mapped access answered with an error");

  property p_overwr_set;
    (sw_cal_wr && loaded_q && !cal_done) |=> overwr_q;
  endproperty
  a_overwr_set: assert property (p_overwr_set)
    else $error("overwrite flag not set by a late software write");

  property p_overwr_clr;
    (acc.wr_en && sel_status && acc.wdata[`ACB_ST_OVERWR]) |=> !overwr_q;
  endproperty
  a_overwr_clr: assert property (p_overwr_clr)
    else $error("overwrite flag not cleared by write one");

  property p_loaded_clr;
    (acc.wr_en && sel_status && acc.wdata[`ACB_ST_LOADED] && !cal_done) |=> !loaded_q;
  endproperty
  a_loaded_clr: assert property (p_loaded_clr)
    else $error("loaded flag not cleared by write one");

  property p_lock_wr;
    (acc.wr_en && sel_ctrl) |=> (lock_q == $past(acc.wdata[`ACB_CTRL_LOCK]));
  endproperty
  a_lock_wr: assert property (p_lock_wr)
    else $error("lock bit did not take the written value");

  property p_status_rd;
    (PSEL && !PENABLE && !PWRITE && sel_status) |=>
      ((PRDATA[31:3] == '0) && (PRDATA[2] == $past(cal_active_q)));
  endproperty
  a_status_rd: assert property (p_status_rd)
    else $error("status read does not show the busy state");

  property p_w_minus_d;
    (wr_hit[4] && !cal_done) |=> (CAL_VALUES.minus_value_d == $past(PWDATA[5:0]));
  endproperty
  a_w_minus_d: assert property (p_w_minus_d)
    else $error("minus word D did not take bits 5 to 0");

  property p_w_minus0;
    (wr_hit[10] && !cal_done) |=> (CAL_VALUES.minus_value0 == $past(PWDATA[5:0]));
  endproperty
  a_w_minus0: assert property (p_w_minus0)
    else $error("minus word 0 did not take bits 5 to 0");

  property p_w_plus0;
    (wr_hit[3] && !cal_done) |=> (CAL_VALUES.plus_value0 == $past(PWDATA[5:0]));
  endproperty
  a_w_plus0: assert property (p_w_plus0)
    else $error("plus word 0 did not take bits 5 to 0");

  c_cal_done: cover property (cal_done);
  c_unmapped_err: cover property (PSEL && PENABLE && PSLVERR);
  c_sw_overwrite: cover property (sw_cal_wr && loaded_q ##1 overwr_q);
  c_locked_write: cover property (acc.wr_en && (|sel) && lock_q);
  c_load_and_write: cover property (cal_done && acc.wr_en);

endmodule : acb_top

// [sim/tb_adc_calibration_value_bank.sv]
// Self-checking bench for the calibration value bank, APB register access and engine loads.
// Assumes acb_pkg compiled first and acb_cfg.svh on the include path.
`timescale 1ns/10ps
`include "acb_cfg.svh"
module tb_adc_calibration_value_bank;

  localparam logic [7:0] OFS [11] = '{`ACB_OFS_PLUS3, `ACB_OFS_PLUS2, `ACB_OFS_PLUS1,
    `ACB_OFS_PLUS0, `ACB_OFS_MINUSD, `ACB_OFS_MINUSS, `ACB_OFS_MINUS4, `ACB_OFS_MINUS3,
    `ACB_OFS_MINUS2, `ACB_OFS_MINUS1, `ACB_OFS_MINUS0};
  localparam int WID [11] = '{`ACB_W_PLUS3, `ACB_W_PLUS2, `ACB_W_PLUS1, `ACB_W_PLUS0,
    `ACB_W_MINUSD, `ACB_W_MINUSS, `ACB_W_MINUS4, `ACB_W_MINUS3, `ACB_W_MINUS2,
    `ACB_W_MINUS1, `ACB_W_MINUS0};

  logic                  clk;
  logic                  rst_n;
  logic                  psel;
  logic                  penable;
  logic                  pwrite;
  logic [7:0]            paddr;
  logic [31:0]           pwdata;
  logic                  cal_active;
  acb_pkg::acb_cal_set_t cal_result;
  logic [31:0]           prdata;
  logic                  pready;
  logic                  pslverr;
  acb_pkg::acb_cal_set_t cal_values;
  logic [32:0]           exp_q [$];
  logic [9:0]            model [11];
  int                    miscompares;
  int                    n_tests;
  int                    cycles;

  acb_top u_acb_top (
    .CORE_CLK   (clk),
    .RST_N      (rst_n),
    .PSEL       (psel),
    .PENABLE    (penable),
    .PWRITE     (pwrite),
    .PADDR      (paddr),
    .PWDATA     (pwdata),
    .PRDATA     (prdata),
    .PREADY     (pready),
    .PSLVERR    (pslverr),
    .CAL_ACTIVE (cal_active),
    .CAL_RESULT (cal_result),
    .CAL_VALUES (cal_values)
  );

  always #25 clk = ~clk;

  function automatic logic [9:0] msk(input int i);
    return 10'h3FF >> (10 - WID[i]);
  endfunction : msk

  // Expected stored set, fields packed in struct order
  function automatic acb_pkg::acb_cal_set_t pack_set();
    logic [81:0] r;
    r = '0;
    for (int i = 0; i < 11; i++) begin
      r = (r << WID[i]) | 82'(model[i]);
    end
    return r;
  endfunction : pack_set

  task automatic check(input logic [84:0] seen, input logic [84:0] want);
    n_tests++;
    if (seen !== want) begin
      miscompares++;
      $display("wrong value at %0t: seen %0h expected %0h", $time, seen, want);
    end
  endtask : check

  task automatic tally_and_finish();
    $display("comparisons %0d mismatches %0d", n_tests, miscompares);
    if (miscompares == 0 && n_tests > 0) begin
      $display("verification passed");
    end else begin
      $display("verification failed");
    end
    $finish;
  endtask : tally_and_finish

  // One APB transfer; expectation {pslverr, read data} noted before it starts
  task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] d,
                     input logic [32:0] e);
    exp_q.push_back(e);
    @(posedge clk);
    psel    <= 1'b1;
    penable <= 1'b0;
    pwrite  <= wr;
    paddr   <= a;
    pwdata  <= d;
    @(posedge clk);
    penable <= 1'b1;
    @(posedge clk);
    while (pready !== 1'b1) @(posedge clk);
    psel    <= 1'b0;
    penable <= 1'b0;
  endtask : apb

  task automatic rd(input int i);
    apb(1'b0, OFS[i], 32'h0000_0000, {1'b0, 22'h00_0000, model[i]});
  endtask : rd

  task automatic wr(input int i, input logic [31:0] d);
    model[i] = d[9:0] & msk(i);
    apb(1'b1, OFS[i], d, 33'h0_0000_0000);
  endtask : wr

  task automatic rd_all();
    for (int i = 0; i < 11; i++) rd(i);
  endtask : rd_all

  // Engine run: busy for a few cycles, result valid in the cycle busy falls
  task automatic calibrate();
    for (int i = 0; i < 11; i++) model[i] = 10'($urandom) & msk(i);
    @(posedge clk);
    cal_active <= 1'b1;
    cal_result <= 82'({$urandom, $urandom, $urandom});
    repeat (3) @(posedge clk);
    cal_active <= 1'b0;
    cal_result <= pack_set();
    @(posedge clk);
    cal_result <= 82'({$urandom, $urandom, $urandom});
    #1;
    check(85'(cal_values), 85'(pack_set()));
  endtask : calibrate

  // Watches each completed transfer and compares with the oldest note
  always @(posedge clk) begin
    if (psel && penable && pready === 1'b1) begin
      if (exp_q.size() == 0) begin
        miscompares++;
      end else begin
        check({52'h0, pslverr, pwrite ? 32'h0000_0000 : prdata}, {52'h0, exp_q.pop_front()});
      end
    end
  end

  always @(posedge clk) begin
    cycles++;
    if (cycles == 3000) begin
      miscompares++;
      tally_and_finish();
    end
  end

  initial begin
    clk = 1'b0; rst_n = 1'b0; psel = 1'b0; penable = 1'b0; pwrite = 1'b0;
    paddr = 8'h00; pwdata = 32'h0000_0000; cal_active = 1'b0; cal_result = '0;
    miscompares = 0; n_tests = 0; cycles = 0;
    for (int i = 0; i < 11; i++) model[i] = 10'h000;
    void'($urandom(32'hFDF9));
    repeat (4) @(posedge clk);
    rst_n <= 1'b1;
    rd_all();
    // All-ones writes show each field width, reserved bits read zero
    for (int i = 0; i < 11; i++) begin
      wr(i, 32'hFFFF_FFFF);
      rd(i);
    end
    // Distinct random values land in distinct registers
    for (int i = 0; i < 11; i++) wr(i, $urandom);
    rd_all();
    #1;
    check(85'(cal_values), 85'(pack_set()));
    // Unmapped and misaligned places answer with an error and change nothing
    apb(1'b0, 8'h3C, 32'h0000_0000, {1'b1, 32'h0000_0000});
    apb(1'b1, 8'h50, 32'hFFFF_FFFF, {1'b1, 32'h0000_0000});
    apb(1'b1, 8'h41, 32'hFFFF_FFFF, {1'b1, 32'h0000_0000});
    apb(1'b0, 8'h78, 32'h0000_0000, {1'b1, 32'h0000_0000});
    rd_all();
    // Engine loads overwrite every value, plus and minus side alike
    for (int n = 0; n < 3; n++) begin
      calibrate();
      rd_all();
    end
    // Late software write is taken, then the next engine run overrides it
    wr(6, 32'hFFFF_FC00 | $urandom);
    wr(3, $urandom);
    rd(6);
    rd(3);
    // Status shows the late write, write one clears both flags
    apb(1'b0, `ACB_OFS_STATUS, 32'h0000_0000, {1'b0, 32'h0000_0003});
    apb(1'b1, `ACB_OFS_STATUS, 32'h0000_0003, 33'h0_0000_0000);
    apb(1'b0, `ACB_OFS_STATUS, 32'h0000_0000, 33'h0_0000_0000);
    calibrate();
    rd_all();
    // Locked registers drop software writes but still take engine loads
    apb(1'b1, `ACB_OFS_CTRL, 32'h0000_0001, 33'h0_0000_0000);
    apb(1'b0, `ACB_OFS_CTRL, 32'h0000_0000, {1'b0, 32'h0000_0001});
    apb(1'b1, OFS[6], $urandom, 33'h0_0000_0000);
    rd(6);
    calibrate();
    apb(1'b1, `ACB_OFS_CTRL, 32'h0000_0000, 33'h0_0000_0000);
    // Write in the cycle the engine finishes is lost
    fork
      calibrate();
      begin
        repeat (2) @(posedge clk);
        apb(1'b1, OFS[0], $urandom, 33'h0_0000_0000);
      end
    join
    apb(1'b0, `ACB_OFS_STATUS, 32'h0000_0000, {1'b0, 32'h0000_0001});
    rd_all();
    repeat (2) @(posedge clk);
    if (exp_q.size() != 0) miscompares++;
    tally_and_finish();
  end

endmodule : tb_adc_calibration_value_bank
